// >>> src/status_bit_source_pkg.sv
// constants and types for the status bit source select block
// Behaviour
// RULE1 - first selector drives bit 9 of motion and action status words
// RULE2 - codes: 0 reserved, 1 current, 2 velocity, 3 position dev, 4 velocity dev
// RULE3 - codes 5 to 8 route position register channels 1 to 4
// RULE4 - code 9 limit switch, 10 relative move after capture, 11 position window
// RULE5 - a new selector value takes effect at once
// RULE6 - second selector drives comm bit 11, action bit 10, motion bit 10
// RULE7 - profile limit selector uses codes 0 to 11, default 0
// RULE8 - position source 0 picks encoder 1, 1 picks encoder 2, default 0
// RULE9 - at power-up take base position from chosen encoder; encoder 1 copies to encoder 2
// RULE10 - position source change stored, active only at next power-up
// RULE11 - selected bits follow condition every cycle; code 0 holds zero
package status_bit_source_pkg;

   localparam int unsigned PARAM_ADDR_W = 16;
   localparam int unsigned PARAM_DATA_W = 16;

   // fieldbus parameter addresses
   localparam logic [15:0] ADDR_ABS_POS_SOURCE   = 16'h054A;
   localparam logic [15:0] ADDR_PROFILE_LIMIT    = 16'h1B3C;
   localparam logic [15:0] ADDR_MOTION_BIT9      = 16'h1B6A;

   localparam logic [15:0] RESET_ABS_POS_SOURCE  = 16'h0000;
   localparam logic [15:0] RESET_PROFILE_LIMIT   = 16'h0000;
   localparam logic [15:0] RESET_MOTION_BIT9     = 16'h000B;

   localparam logic [15:0] SELECT_CODE_MAX       = 16'h000B;
   localparam logic [15:0] SOURCE_CODE_MAX       = 16'h0001;
   localparam logic [15:0] SOURCE_ENCODER_1      = 16'h0000;

   // status word bit positions
   localparam int unsigned MOTION_BIT_A = 9;
   localparam int unsigned ACTION_BIT_A = 9;
   localparam int unsigned MOTION_BIT_B = 10;
   localparam int unsigned ACTION_BIT_B = 10;
   localparam int unsigned COMM_BIT_B   = 11;

   typedef enum logic [3:0] {
      SEL_NONE,
      SEL_CURRENT_BELOW,
      SEL_VELOCITY_BELOW,
      SEL_IN_POS_DEVIATION,
      SEL_IN_VEL_DEVIATION,
      SEL_POS_REG_CH1,
      SEL_POS_REG_CH2,
      SEL_POS_REG_CH3,
      SEL_POS_REG_CH4,
      SEL_HW_LIMIT_SWITCH,
      SEL_REL_MOVE_CAPTURE,
      SEL_POSITION_WINDOW
   } select_code_t;

   // internal motion conditions, one bit each
   typedef struct packed {
      logic       current_below;
      logic       velocity_below;
      logic       in_pos_deviation;
      logic       in_vel_deviation;
      logic [3:0] pos_reg_channel;
      logic       hw_limit_switch;
      logic       relative_move_after_capture;
      logic       position_window;
   } condition_t;

   // status word bits driven by the two selectors
   typedef struct packed {
      logic motion_bit9;
      logic action_bit9;
      logic motion_bit10;
      logic action_bit10;
      logic comm_bit11;
   } status_bits_t;

   typedef struct packed {
      logic        write;
      logic        read;
      logic [15:0] addr;
      logic [15:0] wdata;
   } param_req_t;

endpackage : status_bit_source_pkg

// >>> src/status_bit_source_select.sv
// parameter bank routing motion conditions onto status bits, plus power-up position source
`timescale 1ns/10ps
module status_bit_source_select #(
   parameter int unsigned POS_W = 32
) (
   input  wire logic                                   clock_in,
   input  wire logic                                   resetn_in,
   input  wire logic                                   ce_in,
   input  wire status_bit_source_pkg::param_req_t      param_req_in,
   output logic [15:0]                                 param_rdata_out,
   output logic                                        param_ack_out,
   output logic                                        param_error_out,
   input  wire status_bit_source_pkg::condition_t      conditions_in,
   output status_bit_source_pkg::status_bits_t         status_bits_out,
   input  wire logic                                   power_up_in,
   input  wire logic                                   encoders_valid_in,
   input  wire logic [POS_W-1:0]                       enc1_abs_pos_in,
   input  wire logic [POS_W-1:0]                       enc2_abs_pos_in,
   output logic [POS_W-1:0]                            base_abs_pos_out,
   output logic                                        base_abs_pos_ready_out,
   output logic [POS_W-1:0]                            enc2_sys_pos_out,
   output logic                                        enc2_sys_pos_load_out,
   output logic                                        active_source_out
);

   initial begin
      if (POS_W < 1 || POS_W > 64) begin
         $error("POS_W must lie between 1 and 64");
      end
   end

   typedef enum logic [1:0] {
      PU_WAIT,
      PU_CAPTURE,
      PU_DONE
   } power_up_state_t;

   logic [15:0]        abs_pos_source_reg;
   logic [15:0]        profile_limit_reg;
   logic [15:0]        motion_bit9_reg;
   logic               active_source_reg;
   power_up_state_t    pu_state_reg;

   // condition picked by a selector code; reserved and out-of-range codes give zero
   function automatic logic select_condition(
      input logic [15:0]                        code,
      input status_bit_source_pkg::condition_t  cond
   );
      logic result;
      result = 1'b0;
      if (code <= status_bit_source_pkg::SELECT_CODE_MAX) begin
         unique case (status_bit_source_pkg::select_code_t'(code[3:0]))
            status_bit_source_pkg::SEL_NONE:             result = 1'b0;              // [RULE11]
            status_bit_source_pkg::SEL_CURRENT_BELOW:    result = cond.current_below;    // [RULE2]
            status_bit_source_pkg::SEL_VELOCITY_BELOW:   result = cond.velocity_below;   // [RULE2]
            status_bit_source_pkg::SEL_IN_POS_DEVIATION: result = cond.in_pos_deviation; // [RULE2]
            status_bit_source_pkg::SEL_IN_VEL_DEVIATION: result = cond.in_vel_deviation; // [RULE2]
            status_bit_source_pkg::SEL_POS_REG_CH1:      result = cond.pos_reg_channel[0]; // [RULE3]
            status_bit_source_pkg::SEL_POS_REG_CH2:      result = cond.pos_reg_channel[1]; // [RULE3]
            status_bit_source_pkg::SEL_POS_REG_CH3:      result = cond.pos_reg_channel[2]; // [RULE3]
            status_bit_source_pkg::SEL_POS_REG_CH4:      result = cond.pos_reg_channel[3]; // [RULE3]
            status_bit_source_pkg::SEL_HW_LIMIT_SWITCH:  result = cond.hw_limit_switch;    // [RULE4]
            status_bit_source_pkg::SEL_REL_MOVE_CAPTURE:
               result = cond.relative_move_after_capture;                                 // [RULE4]
            status_bit_source_pkg::SEL_POSITION_WINDOW:  result = cond.position_window;    // [RULE4]
            default:                                     result = 1'b0;
         endcase
      end
      return result;
   endfunction : select_condition

   // true when a write to this address carries a value the parameter accepts
   function automatic logic write_legal(
      input logic [15:0] addr,
      input logic [15:0] data
   );
      logic ok;
      ok = 1'b0;
      if (addr == status_bit_source_pkg::ADDR_ABS_POS_SOURCE) begin
         ok = (data <= status_bit_source_pkg::SOURCE_CODE_MAX);   // [RULE8]
      end else if (addr == status_bit_source_pkg::ADDR_PROFILE_LIMIT ||
                   addr == status_bit_source_pkg::ADDR_MOTION_BIT9) begin
         ok = (data <= status_bit_source_pkg::SELECT_CODE_MAX);   // [RULE4] [RULE7]
      end
      return ok;
   endfunction : write_legal

   logic write_ok;
   assign write_ok = param_req_in.write && write_legal(param_req_in.addr, param_req_in.wdata);

   // parameter storage; illegal values are refused and leave the old value
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         abs_pos_source_reg <= status_bit_source_pkg::RESET_ABS_POS_SOURCE;   // [RULE8]
         profile_limit_reg  <= status_bit_source_pkg::RESET_PROFILE_LIMIT;    // [RULE7]
         motion_bit9_reg    <= status_bit_source_pkg::RESET_MOTION_BIT9;
      end else if (ce_in && write_ok) begin
         unique case (param_req_in.addr)
            status_bit_source_pkg::ADDR_ABS_POS_SOURCE: abs_pos_source_reg <= param_req_in.wdata; // [RULE10]
            status_bit_source_pkg::ADDR_PROFILE_LIMIT:  profile_limit_reg  <= param_req_in.wdata; // [RULE5]
            status_bit_source_pkg::ADDR_MOTION_BIT9:    motion_bit9_reg    <= param_req_in.wdata; // [RULE5]
            default: ;
         endcase
      end
   end

   // read port and write answer, one cycle after the request
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         param_rdata_out <= 16'h0000;
         param_ack_out   <= 1'b0;
         param_error_out <= 1'b0;
      end else if (ce_in) begin
         param_ack_out   <= param_req_in.read || param_req_in.write;
         param_error_out <= param_req_in.write && !write_ok;
         if (param_req_in.read) begin
            unique case (param_req_in.addr)
               status_bit_source_pkg::ADDR_ABS_POS_SOURCE: param_rdata_out <= abs_pos_source_reg;
               status_bit_source_pkg::ADDR_PROFILE_LIMIT:  param_rdata_out <= profile_limit_reg;
               status_bit_source_pkg::ADDR_MOTION_BIT9:    param_rdata_out <= motion_bit9_reg;
               default: begin
                  param_rdata_out <= 16'h0000;
                  param_error_out <= 1'b1;
               end
            endcase
         end
      end
   end

   // status bits follow the live selectors every cycle, so a write shows on the next edge
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         status_bits_out <= '0;
      end else if (ce_in) begin
         status_bits_out.motion_bit9  <= select_condition(motion_bit9_reg, conditions_in);   // [RULE1] [RULE11]
         status_bits_out.action_bit9  <= select_condition(motion_bit9_reg, conditions_in);   // [RULE1]
         status_bits_out.motion_bit10 <= select_condition(profile_limit_reg, conditions_in); // [RULE6]
         status_bits_out.action_bit10 <= select_condition(profile_limit_reg, conditions_in); // [RULE6]
         status_bits_out.comm_bit11   <= select_condition(profile_limit_reg, conditions_in); // [RULE6] [RULE7]
      end
   end

   // power-up sequence: the source is frozen here, so later writes wait for the next power-up
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pu_state_reg      <= PU_WAIT;
         active_source_reg <= 1'b0;
      end else if (ce_in) begin
         if (power_up_in) begin
            pu_state_reg <= PU_WAIT;                                         // [RULE10]
         end else begin
            unique case (pu_state_reg)
               PU_WAIT: begin
                  if (encoders_valid_in) begin
                     active_source_reg <=
                        (abs_pos_source_reg != status_bit_source_pkg::SOURCE_ENCODER_1); // [RULE10]
                     pu_state_reg <= PU_CAPTURE;
                  end
               end
               PU_CAPTURE: pu_state_reg <= PU_DONE;
               PU_DONE:    pu_state_reg <= PU_DONE;
            endcase
         end
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         base_abs_pos_out       <= '0;
         base_abs_pos_ready_out <= 1'b0;
         enc2_sys_pos_out       <= '0;
         enc2_sys_pos_load_out  <= 1'b0;
         active_source_out      <= 1'b0;
      end else if (ce_in) begin
         enc2_sys_pos_load_out <= 1'b0;
         active_source_out     <= active_source_reg;
         if (power_up_in) begin
            base_abs_pos_ready_out <= 1'b0;
         end else if (pu_state_reg == PU_CAPTURE) begin
            base_abs_pos_ready_out <= 1'b1;
            if (!active_source_reg) begin
               base_abs_pos_out      <= enc1_abs_pos_in;                     // [RULE9] [RULE8]
               enc2_sys_pos_out      <= enc1_abs_pos_in;                     // [RULE9]
               enc2_sys_pos_load_out <= 1'b1;                                // [RULE9]
            end else begin
               base_abs_pos_out <= enc2_abs_pos_in;                          // [RULE9] [RULE8]
            end
         end
      end
   end

endmodule : status_bit_source_select

// >>> testbench/fieldbus_master_model.sv
// fieldbus master issuing one parameter access at a time
`timescale 1ns/10ps
module fieldbus_master_model (
   input  wire logic                              clock_in,
   output status_bit_source_pkg::param_req_t      req_out,
   input  wire logic [15:0]                       rdata_in,
   input  wire logic                              ack_in,
   input  wire logic                              error_in
);
   initial req_out = '0;
   // request is a one-cycle pulse; released lines show the inverse so stale values are not trusted
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d,
                       output logic [15:0] rd, output logic er);
      @(posedge clock_in);
      req_out <= '{write: wr, read: !wr, addr: a, wdata: d};
      @(posedge clock_in);
      req_out <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
      #1;
      rd = rdata_in;
      er = ack_in ? error_in : 1'bX;
   endtask : xfer
endmodule : fieldbus_master_model

// >>> testbench/sbs_assertions.sv
// concurrent checks on the status bit source select ports
`timescale 1ns/10ps
module sbs_assertions (
   input wire logic                                clock_in,
   input wire logic                                resetn_in,
   input wire logic                                ce_in,
   input wire status_bit_source_pkg::param_req_t   param_req_in,
   input wire logic                                param_ack_out,
   input wire logic                                param_error_out,
   input wire status_bit_source_pkg::condition_t   conditions_in,
   input wire status_bit_source_pkg::status_bits_t status_bits_out,
   input wire logic                                power_up_in,
   input wire logic                                base_abs_pos_ready_out,
   input wire logic                                enc2_sys_pos_load_out,
   input wire logic                                active_source_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   wire        req_seen = ce_in && (param_req_in.write || param_req_in.read);
   wire        wr_seen  = ce_in && param_req_in.write;
   wire [15:0] wa       = param_req_in.addr;
   wire [15:0] wd       = param_req_in.wdata;
   // motion9, action9, motion10, action10, comm11
   wire [4:0]  sb       = status_bits_out;
   req_ack_a: assert property (req_seen |=> param_ack_out)
      else $error("request not acknowledged");
   bit9_pair_a: assert property (sb[4] == sb[3])
      else $error("bit 9 differs between words");
   fanout_b_a: assert property (sb[2] == sb[1] && sb[1] == sb[0])
      else $error("second selector bits differ");
   zero_code_a: assert property ((wr_seen && wa == 16'h1B6A && wd == 16'h0000)
      ##1 ce_in |=> !sb[4]) else $error("code zero left bit 9 set");
   current_code_a: assert property ((wr_seen && wa == 16'h1B6A && wd == 16'h0001)
      ##1 ce_in |=> sb[4] == $past(conditions_in.current_below))
      else $error("code one not routed at once");
   limit_refuse_a: assert property ((wr_seen && wa == 16'h1B3C && wd > 16'h000B)
      |=> param_error_out) else $error("bad selector value accepted");
   source_refuse_a: assert property ((wr_seen && wa == 16'h054A && wd > 16'h0001)
      |=> param_error_out) else $error("bad source value accepted");
   copy_pulse_a: assert property (enc2_sys_pos_load_out
      |-> !active_source_out && base_abs_pos_ready_out) else $error("copy without encoder 1");
   load_single_a: assert property (ce_in && enc2_sys_pos_load_out |=> !enc2_sys_pos_load_out)
      else $error("copy pulse too long");
   source_hold_a: assert property ((ce_in && !power_up_in && base_abs_pos_ready_out)
      |=> $stable(active_source_out)) else $error("source changed without power-up");
   cover property (enc2_sys_pos_load_out);
   cover property (param_error_out);
   cover property (sb[4] && sb[1]);
endmodule : sbs_assertions

// >>> testbench/status_bit_source_select_test.sv
// self-checking bench for the status bit source select block
`timescale 1ns/10ps
module status_bit_source_select_test;
   logic        clock_in, resetn_in, ce_in, power_up_in, valid, ack, err, ready, act, load;
   logic [15:0] rdata;
   logic [31:0] enc1, enc2, base, sys, rnd;
   int          failures = 0;
   int          n_compared = 0;
   int          seed = 32'h40a47177;
   int          mdl[int];
   status_bit_source_pkg::param_req_t   req;
   status_bit_source_pkg::condition_t   cond;
   status_bit_source_pkg::status_bits_t stat;

   status_bit_source_select i_dut (
      .clock_in(clock_in), .resetn_in(resetn_in), .ce_in(ce_in), .param_req_in(req),
      .param_rdata_out(rdata), .param_ack_out(ack), .param_error_out(err),
      .conditions_in(cond), .status_bits_out(stat), .power_up_in(power_up_in),
      .encoders_valid_in(valid), .enc1_abs_pos_in(enc1), .enc2_abs_pos_in(enc2),
      .base_abs_pos_out(base), .base_abs_pos_ready_out(ready), .enc2_sys_pos_out(sys),
      .enc2_sys_pos_load_out(load), .active_source_out(act));
   fieldbus_master_model i_master (.clock_in(clock_in), .req_out(req), .rdata_in(rdata),
      .ack_in(ack), .error_in(err));

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   function automatic logic pick(int code, status_bit_source_pkg::condition_t c);
      logic [11:0] v;
      v = {c.position_window, c.relative_move_after_capture, c.hw_limit_switch,
           c.pos_reg_channel, c.in_vel_deviation, c.in_pos_deviation, c.velocity_below,
           c.current_below, 1'b0};
      return v[code];
   endfunction : pick

   task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
      logic [15:0] rd;
      logic        er;
      logic        bad;
      bad = !mdl.exists(a) || (wr && d > (a == 16'h054A ? 1 : 11));
      i_master.xfer(wr, a, d, rd, er);
      chk("error", er, bad);
      if (!wr) chk("read data", rd, bad ? 0 : mdl[a]);
      else if (!bad) mdl[a] = d;
   endtask : acc

   task automatic stat_chk();
      repeat (3) begin
         @(posedge clock_in);
         rnd = $random(seed);
         cond <= rnd[10:0];
         @(posedge clock_in);
         #1;
         chk("bit9", {stat.motion_bit9, stat.action_bit9}, {2{pick(mdl[16'h1B6A], cond)}});
         chk("bit10_11", {stat.motion_bit10, stat.action_bit10, stat.comm_bit11},
             {3{pick(mdl[16'h1B3C], cond)}});
      end
   endtask : stat_chk

   task automatic powered(input logic src);
      int n = 0;
      #1;
      while (ready !== 1'b1 && n < 20) begin
         @(posedge clock_in);
         #1;
         n++;
      end
      chk("base", base, src ? enc2 : enc1);
      chk("source", act, src);
      if (!src) chk("copy", sys, enc1);
      chk("copy pulse", load, !src);
   endtask : powered

   task automatic results();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results

   initial begin
      clock_in = 1'b0;
      forever #25 clock_in = ~clock_in;
   end

   // bounded far above the few hundred cycles the sequence needs
   initial begin
      #(50 * 20000);
      failures++;
      results();
   end

   initial begin
      resetn_in = 1'b0;
      ce_in = 1'b1;
      power_up_in = 1'b0;
      valid = 1'b0;
      cond = '0;
      enc1 = $random(seed);
      enc2 = $random(seed);
      mdl[16'h054A] = 0;
      mdl[16'h1B3C] = 0;
      mdl[16'h1B6A] = 11;
      repeat (12) @(posedge clock_in);
      resetn_in <= 1'b1;
      valid <= 1'b1;
      powered(1'b0);
      foreach (mdl[a]) acc(1'b0, 16'(a), 16'h0000);
      acc(1'b0, 16'h0100, 16'h0000);
      for (int c = 0; c <= 12; c++) begin
         acc(1'b1, 16'h1B6A, 16'(c));
         acc(1'b1, 16'h1B3C, 16'(11 - c));
         stat_chk();
      end
      // clock enable low must hold the status bits even though the conditions move
      rnd = 32'(stat);
      @(posedge clock_in);
      ce_in <= 1'b0;
      cond  <= ~cond;
      repeat (2) @(posedge clock_in);
      #1;
      chk("frozen", 32'(stat), rnd);
      @(posedge clock_in);
      ce_in <= 1'b1;
      acc(1'b1, 16'h054A, 16'h0002);
      acc(1'b1, 16'h0100, 16'h0005);
      acc(1'b1, 16'h054A, 16'h0001);
      chk("source kept", act, 1'b0);
      repeat (2) begin
         @(posedge clock_in);
         enc1 <= $random(seed);
         enc2 <= $random(seed);
         power_up_in <= 1'b1;
         @(posedge clock_in);
         power_up_in <= 1'b0;
         @(posedge clock_in);
         powered(mdl[16'h054A] == 1);
         acc(1'b1, 16'h054A, 16'h0000);
      end
      results();
   end
endmodule : status_bit_source_select_test

bind status_bit_source_select sbs_assertions i_chk (
   .clock_in(clock_in), .resetn_in(resetn_in), .ce_in(ce_in), .param_req_in(param_req_in),
   .param_ack_out(param_ack_out), .param_error_out(param_error_out),
   .conditions_in(conditions_in), .status_bits_out(status_bits_out),
   .power_up_in(power_up_in), .base_abs_pos_ready_out(base_abs_pos_ready_out),
   .enc2_sys_pos_load_out(enc2_sys_pos_load_out), .active_source_out(active_source_out));
